// ### hrs_pkg.sv
// Package of constants and types for the hardware return stack
package hrs_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int DEPTH    = 16;
	localparam int PTR_W    = 4;
	localparam int ADDR_W   = 16;

	// ----------------------------------------
	// Reset values and landmarks
	// ----------------------------------------
	localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
	localparam logic [PTR_W-1:0] PTR_TOP   = 4'hF;
	localparam logic             FLAG_RESET = 1'b1;

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		HRS_OP_IDLE = 3'b001,
		HRS_OP_PUSH = 3'b010,
		HRS_OP_POP  = 3'b100
	} hrs_op_t;

endpackage : hrs_pkg

// ### hrs_op_decode.sv
// Decoder from sequencer strobes to a stack operation
`timescale 1ns/1ps
module hrs_op_decode (
	// Sequencer strobes
	input  wire logic       call_exec,
	input  wire logic       irq_vector,
	input  wire logic       return_plain,
	input  wire logic       return_with_literal,
	input  wire logic       return_from_interrupt,
	// Decoded operation
	output hrs_pkg::hrs_op_t op
);
	logic push_req;
	logic pop_req;

	always_comb begin
		push_req = call_exec | irq_vector;
		pop_req  = return_plain | return_with_literal
			| return_from_interrupt;
		// Push wins if the sequencer ever misbehaves and asserts both
		if (push_req)
			op = hrs_pkg::HRS_OP_PUSH;
		else if (pop_req)
			op = hrs_pkg::HRS_OP_POP;
		else
			op = hrs_pkg::HRS_OP_IDLE;
	end
endmodule : hrs_op_decode

// ### hrs_flag_track.sv
// Stack-space flag tracker with lock after pointer roll-over
`timescale 1ns/1ps
module hrs_flag_track (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Pointer movement
	input  wire logic [hrs_pkg::PTR_W-1:0] ptr_next,
	input  wire logic                      wrap_up,
	// Flag state
	output logic                           flag_next,
	output logic                           lock_reg
);
	logic lock_next;

	always_comb begin
		lock_next = lock_reg | wrap_up;
		// Flag is clear at top or once locked; the lock is cleared only by reset
		flag_next = !(lock_next || ptr_next == hrs_pkg::PTR_TOP);
	end

	always_ff @(posedge clk) begin
		if (srst)
			lock_reg <= 1'b0;
		else
			lock_reg <= lock_next;
	end
endmodule : hrs_flag_track

// ### hrs_return_stack.sv
// Hardware return-address stack, sixteen entries of program counter
//
// Functional notes
// - Sixteen 16-bit entries, pointer not software visible
// - Push program counter on call or interrupt
// - Pop into program counter on any return
// - High latch never touched by push/pop
// - Circular pointer, zero after every reset
// - Reset sets stack-space flag
// - Flag clears when pointer reaches Fh
// - Roll-over Fh to 0h locks flag clear
// - Pop at zero wraps; no underflow flag
// - Seventeenth push overwrites the first, onward
`timescale 1ns/1ps
module hrs_return_stack #(
	parameter int DEPTH  = hrs_pkg::DEPTH,
	parameter int ADDR_W = hrs_pkg::ADDR_W
) (
	// Clock and reset
	clk,
	srst,
	// Sequencer strobes
	call_exec,
	irq_vector,
	return_plain,
	return_with_literal,
	return_from_interrupt,
	// Program counter
	pc_value,
	pop_value,
	pop_valid,
	// Status
	stack_space_flag
);
	input  wire logic              clk;
	input  wire logic              srst;
	input  wire logic              call_exec;
	input  wire logic              irq_vector;
	input  wire logic              return_plain;
	input  wire logic              return_with_literal;
	input  wire logic              return_from_interrupt;
	input  wire logic [ADDR_W-1:0] pc_value;
	output logic      [ADDR_W-1:0] pop_value;
	output logic                   pop_valid;
	output logic                   stack_space_flag;

	// ----------------------------------------
	// Storage and pointer
	// ----------------------------------------
	// Dedicated array, outside program and data space; no pointer port
	logic [ADDR_W-1:0] mem [DEPTH];
	logic [hrs_pkg::PTR_W-1:0] ptr_reg;
	logic [hrs_pkg::PTR_W-1:0] ptr_next;
	logic [ADDR_W-1:0]         pop_value_reg;
	logic [ADDR_W-1:0]         pop_value_next;
	logic                      pop_valid_reg;
	logic                      pop_valid_next;
	logic                      flag_reg;
	logic                      flag_next;
	logic                      wrap_up;
	logic                      lock;
	hrs_pkg::hrs_op_t          op;

	// ----------------------------------------
	// Operation decode
	// ----------------------------------------
	hrs_op_decode u_dec (
		.call_exec             (call_exec),
		.irq_vector            (irq_vector),
		.return_plain          (return_plain),
		.return_with_literal   (return_with_literal),
		.return_from_interrupt (return_from_interrupt),
		.op                    (op)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		ptr_next       = ptr_reg;
		pop_value_next = pop_value_reg;
		pop_valid_next = 1'b0;
		wrap_up        = 1'b0;
		case (op)
			hrs_pkg::HRS_OP_PUSH: begin
				// Old entry simply overwritten when full
				ptr_next = ptr_reg + 4'h1;
				wrap_up  = (ptr_reg == hrs_pkg::PTR_TOP);
			end
			hrs_pkg::HRS_OP_POP: begin
				// Zero wraps to Fh; flag then reads as full
				ptr_next       = ptr_reg - 4'h1;
				pop_value_next = mem[ptr_next];
				pop_valid_next = 1'b1;
			end
			hrs_pkg::HRS_OP_IDLE: begin
				ptr_next = ptr_reg;
			end
			default: begin
				ptr_next = ptr_reg;
			end
		endcase
	end

	// ----------------------------------------
	// Flag tracking
	// ----------------------------------------
	hrs_flag_track u_flag (
		.clk       (clk),
		.srst      (srst),
		.ptr_next  (ptr_next),
		.wrap_up   (wrap_up),
		.flag_next (flag_next),
		.lock_reg  (lock)
	);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ptr_reg       <= hrs_pkg::PTR_RESET;
			flag_reg      <= hrs_pkg::FLAG_RESET;
			pop_value_reg <= '0;
			pop_valid_reg <= 1'b0;
		end else begin
			ptr_reg       <= ptr_next;
			flag_reg      <= flag_next;
			pop_value_reg <= pop_value_next;
			pop_valid_reg <= pop_valid_next;
		end
	end

	// Entries are not cleared by reset, matching plain RAM
	always_ff @(posedge clk) begin
		if (!srst && op == hrs_pkg::HRS_OP_PUSH)
			mem[ptr_reg] <= pc_value;
	end

	// Only the counter value is kept; the high latch has no path here
	assign pop_value        = pop_value_reg;
	assign pop_valid        = pop_valid_reg;
	assign stack_space_flag = flag_reg;
endmodule : hrs_return_stack

// ### hrs_seq_model.sv
// Sequencer model that turns an instruction kind into stack strobes
`timescale 1ns/1ps
module hrs_seq_model (
	// Kind: 1 call, 2 interrupt, 3 to 5 the returns
	input wire logic [2:0]	kind,
	// Strobes, one at a time
	output logic		call_exec,
	output logic		irq_vector,
	output logic		return_plain,
	output logic		return_with_literal,
	output logic		return_from_interrupt
);
	assign call_exec = kind == 3'h1;
	assign irq_vector = kind == 3'h2;
	assign return_plain = kind == 3'h3;
	assign return_with_literal = kind == 3'h4;
	assign return_from_interrupt = kind == 3'h5;
endmodule : hrs_seq_model

// ### hrs_return_stack_chk.sv
// Assertion checker for the hardware return stack
`timescale 1ns/1ps
module hrs_return_stack_chk (
	// Watched ports
	input wire logic	clk,
	input wire logic	srst,
	input wire logic	call_exec,
	input wire logic	irq_vector,
	input wire logic	return_plain,
	input wire logic	return_with_literal,
	input wire logic	return_from_interrupt,
	input wire logic [15:0]	pc_value,
	input wire logic [15:0]	pop_value,
	input wire logic	pop_valid,
	input wire logic	stack_space_flag
);
	// Push wins when both arrive together
	wire push = call_exec | irq_vector;
	wire pop = !push & (return_plain | return_with_literal
		| return_from_interrupt);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_push_pop;
		push ##1 pop;
	endsequence
	a_pop_valid: assert property (pop |=> pop_valid)
		else $error("pop_valid missing");
	a_valid_cause: assert property (!pop |=> !pop_valid)
		else $error("pop_valid stray");
	a_value_hold: assert property (!pop |=> $stable(pop_value))
		else $error("pop_value moved");
	a_reset_state: assert property ($fell(srst) |-> stack_space_flag
		&& !pop_valid && pop_value == 16'h0000) else $error("bad reset");
	a_lifo_order: assert property (s_push_pop |=>
		pop_value == $past(pc_value, 2)) else $error("wrong pop");
	a_flag_lock: assert property (!stack_space_flag && push |=>
		!stack_space_flag) else $error("flag rose");
	a_flag_idle: assert property (!push && !pop |=>
		$stable(stack_space_flag)) else $error("flag moved");
	a_pop_zero: assert property ($fell(srst) && pop |=>
		!stack_space_flag) else $error("flag set at wrap");
endmodule : hrs_return_stack_chk

bind hrs_return_stack hrs_return_stack_chk u_chk (.clk, .srst, .call_exec,
	.irq_vector, .return_plain, .return_with_literal, .return_from_interrupt,
	.pc_value, .pop_value, .pop_valid, .stack_space_flag);

// ### testbench.sv
// Self-checking testbench for the hardware return stack
`timescale 1ns/1ps
module testbench;
	logic		clk;
	logic		srst = 1'h1;
	logic [2:0]	kind = 3'h0;
	logic [15:0]	pc_value = 16'h0000;
	logic		call_exec, irq_vector, return_plain;
	logic		return_with_literal, return_from_interrupt;
	logic [15:0]	pop_value;
	logic		pop_valid, stack_space_flag;
	int		err_count, comparisons, ptr, lock, ev, vv;
	int		mem[16];
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	hrs_seq_model seq (.kind, .call_exec, .irq_vector, .return_plain,
		.return_with_literal, .return_from_interrupt);
	hrs_return_stack dut (.clk, .srst, .call_exec, .irq_vector,
		.return_plain, .return_with_literal, .return_from_interrupt,
		.pc_value, .pop_value, .pop_valid, .stack_space_flag);
	task chk(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Releases reset on a falling edge; entries survive reset
	task do_reset;
		kind = 3'h0;
		srst = 1'h1;
		repeat (6) @(negedge clk);
		srst = 1'h0;
		ptr = 0;
		lock = 0;
		ev = 0;
		chk("flag", stack_space_flag, 1);
		chk("valid", pop_valid, 0);
		chk("value", pop_value, 0);
	endtask : do_reset
	task step(input int k, input logic [15:0] p);
		kind = k[2:0];
		pc_value = p;
		@(posedge clk);
		vv = k > 2;
		if (k == 1 || k == 2) begin
			mem[ptr] = p;
			lock |= ptr == 15;
			ptr = (ptr + 1) % 16;
		end else if (vv) begin
			ptr = (ptr + 15) % 16;
			ev = mem[ptr];
		end
		@(negedge clk);
		chk("flag", stack_space_flag, ptr != 15 && !lock);
		chk("valid", pop_valid, vv);
		chk("value", pop_value, ev);
	endtask : step
	task end_of_test;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		void'($urandom(43354));
		do_reset;
		$display("reset test done");
		for (int i = 0; i < 18; i++) step(1 + i % 2, 16'($urandom));
		for (int i = 0; i < 17; i++) step(3 + i % 3, 16'($urandom));
		$display("fill test done");
		do_reset;
		step(3, 16'h0000);
		step(1, 16'h1234);
		step(4, 16'h0000);
		$display("wrap test done");
		do_reset;
		repeat (400) step($urandom % 6, 16'($urandom));
		$display("random test done");
		end_of_test;
	end
	initial begin
		#20000;
		err_count++;
		end_of_test;
	end
endmodule : testbench
